// >>> rtl/cfd_fanout.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfd_params.svh"
// Contract
// R1: Accept differential or single-ended CMOS reference
// R2: Route input into dividers with phase offset
// R3: Serial control ratios one through 1024
// R4: Serial phase offset is eleven bits
// R5: Strapping limits ratio to sixteen maximum
// R6: Strapping forces zero phase offset
// R7: Four differential or eight CMOS outputs
// R8: Per-output drive strength setting
// R9: Select pin picks SPI, I2C or strapping
// R10: Input select high differential, low CMOS
// R11: Sync low holds outputs, rising restarts aligned
// R12: Fifty percent duty for any ratio
// R13: Phase step is half input period
module cfd_fanout import cfd_pkg::*; #(
  parameter int NUM_OUT = `CFD_NUM_OUT,
  parameter int DIV_W = `CFD_DIV_W,
  parameter int PHASE_W = `CFD_PHASE_W,
  parameter int DRIVE_W = `CFD_DRIVE_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ref_true_in, // Sampled reference, true leg
  input wire logic ref_comp_in, // Sampled reference, complement leg
  input wire logic input_diff_sel_in, // High differential, low single-ended
  input wire logic [1:0] control_interface_select_in, // Decoded tri-level pin
  input wire logic sync_n_in, // Active low output alignment
  input wire logic [NUM_OUT*DIV_W-1:0] ser_ratio_m1_in, // Serial ratios minus one
  input wire logic [NUM_OUT*PHASE_W-1:0] ser_phase_in, // Serial phase offsets
  input wire logic [NUM_OUT*4-1:0] strap_ratio_m1_in, // Strap ratios minus one
  input wire logic [NUM_OUT*2-1:0] out_std_in, // Per-output standard
  input wire logic [NUM_OUT*DRIVE_W-1:0] drive_in, // Per-output drive code
  output logic [1:0] active_if_out, // 0 SPI, 1 I2C, 2 strapped
  output logic [NUM_OUT-1:0] diff_p_out,
  output logic [NUM_OUT-1:0] diff_n_out,
  output logic [NUM_OUT-1:0] diff_oe_out,
  output logic [2*NUM_OUT-1:0] cmos_out,
  output logic [2*NUM_OUT-1:0] cmos_oe_out,
  output logic [NUM_OUT*DRIVE_W-1:0] drive_out
);
  // Whole top state in one packed struct
  typedef struct packed {
    cfd_if_t mode;
    logic ref_prev;
    logic [NUM_OUT-1:0] dp;
    logic [NUM_OUT-1:0] dn;
    logic [NUM_OUT-1:0] doe;
    logic [2*NUM_OUT-1:0] cm;
    logic [2*NUM_OUT-1:0] coe;
    logic [NUM_OUT*DRIVE_W-1:0] drv;
    logic [1:0] aif;
    logic armed; // Mode still open to the select pin
  } cfd_top_state_t;
  cfd_top_state_t st_reg;
  cfd_top_state_t st_next;
  // Helper nets between the input stage, the mode limits and the dividers
  logic ref_sel; // Selected reference level
  logic half_en; // Pulse on each input edge, one per half period
  logic hold; // Sync held low
  logic [NUM_OUT-1:0] div_clk; // Divider outputs
  logic [NUM_OUT*DIV_W-1:0] eff_ratio; // Ratios after mode limits
  logic [NUM_OUT*PHASE_W-1:0] eff_phase; // Phases after mode limits

  // Map the tri-level pin to a mode; an unused code falls back to SPI
  function automatic cfd_if_t cfd_decode_sel(input logic [1:0] sel);
    unique case (sel)
      `CFD_SEL_LOW: cfd_decode_sel = CFD_IF_I2C; // R9
      `CFD_SEL_HIGH: cfd_decode_sel = CFD_IF_PIN; // R9
      default: cfd_decode_sel = CFD_IF_SPI; // R9
    endcase
  endfunction : cfd_decode_sel

  // Report code of a mode on the status port; an illegal mode code reads as SPI
  function automatic logic [1:0] cfd_encode_if(input cfd_if_t mode);
    unique case (mode)
      CFD_IF_I2C: cfd_encode_if = 2'h1;
      CFD_IF_PIN: cfd_encode_if = 2'h2;
      default: cfd_encode_if = 2'h0;
    endcase
  endfunction : cfd_encode_if

  // Reference select; differential uses the sign of the pair, CMOS ignores the complement
  // Limitation: a differential pair with no swing gives no ticks, so every output stalls
  always_comb begin
    if (input_diff_sel_in) begin // R10
      ref_sel = ref_true_in & ~ref_comp_in; // R1
    end else begin
      ref_sel = ref_true_in; // R1
    end
    // Input edges of either direction step the dividers by half a period
    half_en = ref_sel ^ st_reg.ref_prev; // R2
    hold = ~sync_n_in; // R11
  end

  // Apply mode limits to ratio and phase
  // Limits sit ahead of the dividers so a held output always restarts in range
  always_comb begin
    eff_ratio = '0;
    eff_phase = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (st_reg.mode == CFD_IF_PIN) begin
        // Strap ratio is four bits, so sixteen is the largest it can give
        eff_ratio[i*DIV_W +: DIV_W] = {{(DIV_W-4){1'b0}}, strap_ratio_m1_in[i*4 +: 4]}; // R5
        eff_phase[i*PHASE_W +: PHASE_W] = '0; // R6
      end else begin
        eff_ratio[i*DIV_W +: DIV_W] = ser_ratio_m1_in[i*DIV_W +: DIV_W]; // R3
        eff_phase[i*PHASE_W +: PHASE_W] = ser_phase_in[i*PHASE_W +: PHASE_W]; // R4
      end
    end
  end

  // One divider per output pair
  // All dividers share one tick and one hold, which keeps the pairs aligned after sync
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_div
    cfd_divider #(.DIV_W(DIV_W), .PHASE_W(PHASE_W)) u_div (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .half_en_in(half_en),
      .hold_in(hold),
      .ratio_m1_in(eff_ratio[g*DIV_W +: DIV_W]),
      .phase_in(eff_phase[g*PHASE_W +: PHASE_W]),
      .clk_out(div_clk[g])
    );
  end

  // Output stage: one pair drives either differential or two CMOS legs
  // The pair registers add one cycle after the divider, so all pins leave together
  always_comb begin
    st_next = st_reg;
    st_next.ref_prev = ref_sel;
    // Mode is taken once, on the first edge after reset, then frozen like a strap
    // A change of the select pin after release is ignored until the next reset
    if (st_reg.armed) begin
      st_next.mode = cfd_decode_sel(control_interface_select_in); // R9
    end
    st_next.armed = 1'b0;
    st_next.aif = cfd_encode_if(st_reg.mode); // R9
    for (int i = 0; i < NUM_OUT; i++) begin
      if (out_std_in[i*2 +: 2] == CFD_OUT_CMOS) begin // R7
        // Differential driver tristated while CMOS legs run
        st_next.doe[i] = 1'b0;
        st_next.dp[i] = 1'b0;
        st_next.dn[i] = 1'b0;
        st_next.coe[2*i +: 2] = 2'h3;
        st_next.cm[2*i +: 2] = {2{div_clk[i]}};
      end else begin
        st_next.doe[i] = 1'b1;
        st_next.dp[i] = div_clk[i];
        st_next.dn[i] = ~div_clk[i];
        st_next.coe[2*i +: 2] = 2'h0;
        st_next.cm[2*i +: 2] = 2'h0;
      end
      // Drive code is registered with the pins so a change lands on both at once
      // Strapped parts run at nominal drive only
      if (st_reg.mode == CFD_IF_PIN) begin
        st_next.drv[i*DRIVE_W +: DRIVE_W] = DRIVE_W'(`CFD_DRIVE_NOMINAL); // R8
      end else begin
        st_next.drv[i*DRIVE_W +: DRIVE_W] = drive_in[i*DRIVE_W +: DRIVE_W]; // R8
      end
    end
  end

  // Register the state
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // Reset leaves the mode open so the select pin is read once released
      st_reg <= '0;
      st_reg.mode <= CFD_IF_SPI;
      st_reg.armed <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Ports read the registered state directly, with no logic after the flops
  assign active_if_out = st_reg.aif;
  assign diff_p_out = st_reg.dp;
  assign diff_n_out = st_reg.dn;
  assign diff_oe_out = st_reg.doe;
  assign cmos_out = st_reg.cm;
  assign cmos_oe_out = st_reg.coe;
  assign drive_out = st_reg.drv;
endmodule : cfd_fanout
`default_nettype wire

// >>> shared/cfd_params.svh
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH
// Number of differential output pairs
`define CFD_NUM_OUT 4
// Divider field width, ratio is field value plus one (1..1024)
`define CFD_DIV_W 10
// Phase offset field width in half input periods
`define CFD_PHASE_W 11
// Largest ratio allowed while strapped
`define CFD_STRAP_DIV_MAX 16
// Drive strength field width
`define CFD_DRIVE_W 3
// Nominal drive code, forced while strapped
`define CFD_DRIVE_NOMINAL 3'h2
// Interface select encodings on the tri-level pin
`define CFD_SEL_LOW 2'h0
`define CFD_SEL_HIGH 2'h1
`define CFD_SEL_FLOAT 2'h2
// Maximum input rate of the distribution stage in MHz
`define CFD_FIN_MAX_MHZ 1650
`endif

// >>> shared/cfd_pkg.sv
`include "cfd_params.svh"
package cfd_pkg;
  // Control interface selected from the tri-level pin
  typedef enum logic [2:0] {
    CFD_IF_SPI = 3'h1,
    CFD_IF_I2C = 3'h2,
    CFD_IF_PIN = 3'h4
  } cfd_if_t;
  // Output stage standard
  typedef enum logic [1:0] {
    CFD_OUT_LVDS = 2'h0,
    CFD_OUT_HSTL = 2'h1,
    CFD_OUT_CMOS = 2'h2
  } cfd_std_t;
endpackage : cfd_pkg

// >>> rtl/cfd_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfd_params.svh"
// One output divider; runs at twice the input rate by working on half periods
module cfd_divider #(
  parameter int DIV_W = `CFD_DIV_W,
  parameter int PHASE_W = `CFD_PHASE_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic half_en_in,
  input wire logic hold_in,
  input wire logic [DIV_W-1:0] ratio_m1_in,
  input wire logic [PHASE_W-1:0] phase_in,
  output logic clk_out
);
  // Whole divider state in one packed struct
  typedef struct packed {
    logic [PHASE_W-1:0] delay;
    logic [DIV_W:0] cnt;
    logic out;
  } cfd_div_state_t;
  cfd_div_state_t st_reg;
  cfd_div_state_t st_next;
  logic [DIV_W:0] last_cnt; // Last half period of an output period, twice the ratio minus one

  // Count half periods: output toggles at 0 and at the ratio, which gives 50% for odd ratios too
  always_comb begin
    st_next = st_reg;
    last_cnt = {ratio_m1_in, 1'b1};
    if (hold_in) begin // R11
      // Static low while held; the phase delay is reloaded so the restart is aligned
      // Count parks on its end so the first counting tick after release wraps to zero and goes high
      st_next.out = 1'b0;
      st_next.cnt = last_cnt;
      st_next.delay = phase_in; // R13
    end else if (half_en_in) begin
      if (st_reg.delay != '0) begin
        // Each step waits one half input period before counting starts
        st_next.delay = st_reg.delay - {{(PHASE_W-1){1'b0}}, 1'b1}; // R13
      end else begin
        if (st_reg.cnt == last_cnt) begin
          st_next.cnt = '0;
        end else begin
          st_next.cnt = st_reg.cnt + {{DIV_W{1'b0}}, 1'b1};
        end
        // High for the first half of the output period
        st_next.out = (st_next.cnt < {1'b0, ratio_m1_in} + {{DIV_W{1'b0}}, 1'b1}); // R12
      end
    end
  end

  // Register the state
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_out = st_reg.out;
endmodule : cfd_divider
`default_nettype wire

// >>> sim/cfd_fanout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfd_params.svh"
// Port checker; the age gate skips the edges in which the mode is latched
module cfd_fanout_monitor #(
  parameter int NUM_OUT = `CFD_NUM_OUT,
  parameter int DRIVE_W = `CFD_DRIVE_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [1:0] control_interface_select_in,
  input wire logic sync_n_in,
  input wire logic [NUM_OUT*2-1:0] out_std_in,
  input wire logic [NUM_OUT*DRIVE_W-1:0] drive_in,
  input wire logic [1:0] active_if_out,
  input wire logic [NUM_OUT-1:0] diff_p_out,
  input wire logic [NUM_OUT-1:0] diff_n_out,
  input wire logic [NUM_OUT-1:0] diff_oe_out,
  input wire logic [2*NUM_OUT-1:0] cmos_out,
  input wire logic [2*NUM_OUT-1:0] cmos_oe_out,
  input wire logic [NUM_OUT*DRIVE_W-1:0] drive_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [3:0] age_reg; // Edges since reset, saturating
  logic [NUM_OUT-1:0] leg_ev, leg_od, oe_ev, is_cmos; // Per-pair views
  logic [1:0] want_if; // Decoded select pin, float codes mean SPI
  // Saturating age counter
  always_ff @(posedge sys_clk_in) age_reg <= srst_in ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
  // Split legs and standards per pair
  always_comb begin
    want_if = control_interface_select_in == 2'h0 ? 2'h1 : control_interface_select_in == 2'h1 ? 2'h2 : 2'h0;
    for (int i = 0; i < NUM_OUT; i++) begin
      leg_ev[i] = cmos_out[2*i];
      leg_od[i] = cmos_out[2*i+1];
      oe_ev[i] = cmos_oe_out[2*i];
      is_cmos[i] = out_std_in[2*i+:2] == 2'h2;
    end
  end
  sequence s_drv_calm; (age_reg > 4'h4 && active_if_out != 2'h2 && $stable(drive_in)) [*2]; endsequence
  sequence s_std_calm; (age_reg > 4'h4 && $stable(out_std_in)) [*3]; endsequence
  sequence s_held; !sync_n_in [*3]; endsequence
  AST_IF_SELECT: assert property (age_reg > 4'h4 |-> active_if_out == want_if)
    else $error("active interface differs from select pin");
  AST_STRAP_DRIVE: assert property (age_reg > 4'h4 && active_if_out == 2'h2 |-> drive_out == {NUM_OUT{DRIVE_W'(`CFD_DRIVE_NOMINAL)}})
    else $error("strapped drive not nominal");
  AST_SER_DRIVE: assert property (s_drv_calm |-> drive_out == drive_in)
    else $error("serial drive not passed through");
  AST_SYNC_HOLD: assert property (s_held |-> diff_p_out == '0 && cmos_out == '0)
    else $error("outputs move while sync held");
  AST_STRAP_PHASE: assert property (age_reg > 4'h4 && active_if_out == 2'h2 && $rose(sync_n_in) |-> ##[1:4] diff_p_out[0])
    else $error("strapped output delayed after sync");
  AST_CMOS_PAIR: assert property (((leg_ev ^ leg_od) & oe_ev) == '0)
    else $error("cmos legs of a pair differ");
  AST_OE_EXCL: assert property ((diff_oe_out & oe_ev) == '0)
    else $error("pair drives both standards");
  AST_DIFF_COMP: assert property ((diff_n_out ^ diff_p_out) == diff_oe_out)
    else $error("differential legs not complementary");
  AST_STD_OE: assert property (s_std_calm |-> oe_ev == is_cmos && diff_oe_out == ~is_cmos)
    else $error("enables do not follow standard");
endmodule : cfd_fanout_monitor
bind cfd_fanout cfd_fanout_monitor #(.NUM_OUT(NUM_OUT), .DRIVE_W(DRIVE_W)) u_mon (.sys_clk_in(sys_clk_in),
  .srst_in(srst_in), .control_interface_select_in(control_interface_select_in), .sync_n_in(sync_n_in),
  .out_std_in(out_std_in), .drive_in(drive_in), .active_if_out(active_if_out), .diff_p_out(diff_p_out),
  .diff_n_out(diff_n_out), .diff_oe_out(diff_oe_out),
  .cmos_out(cmos_out), .cmos_oe_out(cmos_oe_out), .drive_out(drive_out));
`default_nettype wire

// >>> sim/cfd_clk_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Clock receiver: run lengths and delay from sync release to first rise
module cfd_clk_rx (
  input wire logic clk_in,
  input wire logic sync_n_in,
  input wire logic line_in,
  output var int hi_out,
  output var int lo_out,
  output var int lat_out
);
  int run_reg; // Cycles at present level
  int wait_reg; // Cycles since release
  logic last_reg; // Previous level
  logic seen_reg; // First rise seen, so the phase wait is not a low run
  // Measure on every edge; sync low forgets all since alignment restarts
  always_ff @(posedge clk_in) begin
    if (!sync_n_in) begin
      {run_reg, wait_reg, hi_out, lo_out, lat_out} <= '0;
      {last_reg, seen_reg} <= 2'h0;
    end else begin
      last_reg <= line_in;
      wait_reg <= wait_reg + 1;
      if (line_in && !seen_reg) begin
        seen_reg <= 1'b1;
        lat_out <= wait_reg;
      end
      if (line_in != last_reg) begin
        run_reg <= 1;
        if (last_reg) hi_out <= run_reg;
        else if (seen_reg) lo_out <= run_reg;
      end else run_reg <= run_reg + 1;
    end
  end
endmodule : cfd_clk_rx
`default_nettype wire

// >>> sim/cfd_fanout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfd_params.svh"
module cfd_fanout_tb_top;
  logic clk = 0, srst = 1, rt = 0, rc = 0, dsel = 1, sync_n = 0, bad = 0; // Clock, reset, reference, controls
  logic [1:0] sel = 2'h2; // Select pin code
  logic [39:0] ratio = '0; // Serial ratios minus one
  logic [43:0] phase = '0; // Serial phases
  logic [15:0] sratio = '0; // Strap ratios minus one
  logic [7:0] std = '0; // Output standards
  logic [11:0] drv = '0; // Drive codes
  logic [1:0] act;
  logic [3:0] dp, dn, doe;
  logic [7:0] co, coe;
  logic [11:0] dro;
  int hi, lo, lat, num_errors = 0, checked = 0, seed = 9;
  // Release to first sampled rise: divider flop, pin flop, then the receiver's own sample
  localparam int SYNC_LAT = 2;
  always #2 clk = ~clk;
  // Reference ticks every cycle; comp leg random in CMOS, equal to true when bad
  always @(posedge clk) begin
    rt <= ~rt;
    rc <= bad ? ~rt : dsel ? rt : 1'($random(seed));
  end
  cfd_fanout dut (.sys_clk_in(clk), .srst_in(srst), .ref_true_in(rt), .ref_comp_in(rc), .input_diff_sel_in(dsel),
    .control_interface_select_in(sel), .sync_n_in(sync_n), .ser_ratio_m1_in(ratio), .ser_phase_in(phase),
    .strap_ratio_m1_in(sratio), .out_std_in(std), .drive_in(drv), .active_if_out(act), .diff_p_out(dp),
    .diff_n_out(dn), .diff_oe_out(doe), .cmos_out(co), .cmos_oe_out(coe), .drive_out(dro));
  cfd_clk_rx u_rx (.clk_in(clk), .sync_n_in(sync_n), .line_in(dp[0]), .hi_out(hi), .lo_out(lo), .lat_out(lat));
  // Select code 0 is I2C, 1 is strapped, the float codes are SPI
  function automatic logic [1:0] want_if(input int m);
    return m == 0 ? 2'h1 : m == 1 ? 2'h2 : 2'h0;
  endfunction : want_if
  // Phase steps of half an input period apply only under serial control
  function automatic int want_lat(input int p, input logic s);
    return s ? SYNC_LAT : SYNC_LAT + p;
  endfunction : want_lat
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      num_errors++;
    end
  endtask : chk
  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Program all pairs with one ratio and phase, pulse sync, then measure pair 0
  task automatic run(input int n, input int p, input logic s);
    int t;
    @(posedge clk);
    sync_n <= 1'b0;
    ratio <= {4{10'(n - 1)}};
    sratio <= {4{4'(n - 1)}};
    phase <= {4{11'(p)}};
    drv <= 12'($random(seed));
    std <= {4'ha, 3'h0, 1'(p)}; // Pairs 3,2 CMOS; 1 LVDS; 0 LVDS or HSTL
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    for (t = 0; t < 6000 && lo == 0; t++) @(posedge clk);
    #1;
    if (t == 6000) begin // Hung: count it and close
      num_errors++;
      stop_test();
    end else begin
      chk("high", hi, n);
      chk("low", lo, n);
      chk("delay", lat, want_lat(p, s));
      chk("drive", dro, s ? {4{`CFD_DRIVE_NOMINAL}} : drv);
    end
  endtask : run
  // One reset per select code, since the mode is latched at release
  initial begin
    for (int m = 0; m < 4; m++) begin
      sel <= 2'(m);
      srst <= 1'b1;
      dsel <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk("mode", act, want_if(m));
      run(m == 1 ? 16 : 1024, 0, m == 1);
      run(1, 2047, m == 1);
      dsel <= 1'b0; // Single-ended on the true leg, comp noise ignored
      run(1 + {$random(seed)} % (m == 1 ? 8 : 64), {$random(seed)} % 2048, m == 1);
      if (m == 0) begin // Differential with no swing between legs must stay quiet
        dsel <= 1'b1;
        bad <= 1'b1;
        sync_n <= 1'b0;
        repeat (4) @(posedge clk);
        sync_n <= 1'b1;
        repeat (100) @(posedge clk);
        #1;
        chk("quiet", hi, 0);
        bad <= 1'b0;
      end
      $display("mode %0d done", m);
    end
    stop_test();
  end
endmodule : cfd_fanout_tb_top
`default_nettype wire
